//--- inc/sbp_pkg.sv
// Purpose: Shared constants and carrier types for the SPI byte port
// Assumes: CPU clock of 25 MHz drives every register of the port
// Notes:   Control and status fields travel as packed structs
package sbp_pkg;

	// ----------------------------------------------------------------
	// Control field and data register reset values
	// ----------------------------------------------------------------
	localparam logic       RST_IRQ_ENABLE  = 1'b0;
	localparam logic       RST_PORT_ENABLE = 1'b0;
	localparam logic       RST_MASTER      = 1'b0;
	localparam logic [2:0] RST_RATE        = 3'h0;
	localparam logic [7:0] RST_DATA        = 8'h00;

	// ----------------------------------------------------------------
	// Transfer geometry and clock divider codes
	// ----------------------------------------------------------------
	localparam int         BITS_PER_BYTE = 8;
	localparam logic [3:0] LAST_EDGE     = 4'hf;
	localparam logic [2:0] RATE_DIV2     = 3'h4;
	localparam logic [2:0] RATE_DIV8     = 3'h0;
	localparam logic [2:0] RATE_DIV16    = 3'h1;
	localparam logic [2:0] RATE_DIV32    = 3'h6;
	localparam logic [2:0] RATE_DIV64    = 3'h2;
	localparam logic [2:0] RATE_DIV128   = 3'h3;
	// Half periods in CPU cycles, one less than the count
	localparam logic [5:0] HALF_DIV2     = 6'h00;
	localparam logic [5:0] HALF_DIV8     = 6'h03;
	localparam logic [5:0] HALF_DIV16    = 6'h07;
	localparam logic [5:0] HALF_DIV32    = 6'h0f;
	localparam logic [5:0] HALF_DIV64    = 6'h1f;
	localparam logic [5:0] HALF_DIV128   = 6'h3f;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       serial_irq_enable;
		logic       port_enable;
		logic       master_select;
		logic       clock_polarity;
		logic       clock_phase;
		logic [2:0] rate;
	} sbp_ctrl_t;

	typedef struct packed {
		logic transfer_done_flag;
		logic write_collision_flag;
		logic mode_fault_flag;
	} sbp_status_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_SHIFT = 3'b010,
		ST_DONE  = 3'b100
	} sbp_state_t;

endpackage : sbp_pkg

//--- core/sbp_port.sv
// Purpose: Byte-wide SPI port, master or slave, with CPU-side strobes
// Assumes: SCK, MOSI and select sampled through three flops, MISO not; one 25 MHz clock
// Notes:   Slave SCK must stay well below the CPU clock rate
//
// Summary of operation
// - Master drives SCK, slave receives it
// - Master data write starts a byte
// - Master shifts MSB first on MOSI, samples MISO
// - Slave shifts MSB first on MISO
// - Eight clock pulses, one bit each way
// - Done flag set; interrupt when enabled, unmasked
// - Received byte buffered; reads return buffer
// - Done flag cleared by status then data access
// - Data writes ignored while done and unread
// - Rate select ignored in slave mode
// - Polarity sets SCK idle level
// - Phase selects first or second capture edge
// - Master presents MOSI one edge early
// - Slave select low locks data register in phase 0; phase 1 locks on first edge
// - Write during transfer discarded, collision flagged
// - Phase 0 slave collides after select falls
// - Phase 1 slave drives MISO on first edge
// - Select low in master mode faults
// - Fault cleared by status then control write
// - Fault blocks enable and master set
// - Overrun keeps first byte, no flag
// - Rate bits select CPU divide ratio
// - Port enable connects pins, reset clears
module sbp_port (
	input  wire logic                 ref_clk_i,
	input  wire logic                 rst_n_i,
	input  wire logic                 irq_mask_i,
	input  wire logic                 ctrl_wr_i,
	input  wire sbp_pkg::sbp_ctrl_t   ctrl_wdata_i,
	input  wire logic                 status_rd_i,
	input  wire logic                 data_wr_i,
	input  wire logic                 data_rd_i,
	input  wire logic [7:0]           data_wdata_i,
	output logic [7:0]                data_rdata_o,
	output sbp_pkg::sbp_ctrl_t        ctrl_o,
	output sbp_pkg::sbp_status_t      status_o,
	output logic                      irq_o,
	output logic                      busy_o,
	input  wire logic                 sck_i,
	output logic                      sck_o,
	output logic                      sck_oe_n_o,
	input  wire logic                 mosi_i,
	output logic                      mosi_o,
	output logic                      mosi_oe_n_o,
	input  wire logic                 miso_i,
	output logic                      miso_o,
	output logic                      miso_oe_n_o,
	input  wire logic                 ss_n_i
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] sck_sync;
	logic [2:0] mosi_sync;
	logic [2:0] ss_sync;
	logic       sck_s;
	logic       mosi_s;
	logic       ss_n_s;
	// MISO has no synchroniser: as master it answers edges of our own
	// SCK, so it is settled long before the capture edge; as slave it
	// is an output

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sck_sync  <= 3'h0;
			mosi_sync <= 3'h0;
			ss_sync   <= 3'h7;
		end else begin
			sck_sync  <= {sck_sync[1:0], sck_i};
			mosi_sync <= {mosi_sync[1:0], mosi_i};
			ss_sync   <= {ss_sync[1:0], ss_n_i};
		end
	end

	// Filtered levels change only when stages two and three agree
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sck_s  <= 1'b0;
			mosi_s <= 1'b0;
			ss_n_s <= 1'b1;
		end else begin
			if (sck_sync[1] == sck_sync[2])
				sck_s <= sck_sync[2];
			if (mosi_sync[1] == mosi_sync[2])
				mosi_s <= mosi_sync[2];
			if (ss_sync[1] == ss_sync[2])
				ss_n_s <= ss_sync[2];
		end
	end

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	sbp_pkg::sbp_ctrl_t   ctrl;
	sbp_pkg::sbp_status_t stat;
	sbp_pkg::sbp_state_t  state;
	logic [7:0]           shift_reg;
	logic [7:0]           rx_buf;
	logic                 rx_held;
	logic [3:0]           edge_cnt;
	logic [5:0]           div_cnt;
	logic [5:0]           half_len;
	logic                 sck_gen;
	logic                 sck_prev;
	logic                 ss_prev;
	logic                 out_bit;
	logic                 done_armed;
	logic                 fault_armed;
	logic                 is_master;
	logic                 slave_sel;
	logic                 slave_frozen;
	logic                 slave_edge;
	logic                 master_edge;
	logic                 any_edge;
	logic                 cap_edge;
	logic                 fault_evt;
	logic                 data_wr_ok;
	logic                 collision;
	logic                 byte_end;
	logic                 data_acc;
	logic                 rx_in;
	logic                 dr_open;

	assign is_master  = ctrl.master_select;
	assign slave_sel  = ctrl.port_enable && !is_master && !ss_n_s;
	// Slave edges count only while selected, so stray SCK is ignored
	assign slave_edge = slave_sel && (sck_s != sck_prev);
	assign any_edge   = is_master ? master_edge : slave_edge;
	// Odd edges (count 0,2,..) capture with phase 0, even with phase 1
	assign cap_edge   = any_edge && (edge_cnt[0] == ctrl.clock_phase);
	assign byte_end   = any_edge && edge_cnt == sbp_pkg::LAST_EDGE;
	// A master that sees its select low gives up the bus at once
	assign fault_evt  = is_master && ctrl.port_enable && !ss_n_s;
	assign data_acc   = data_wr_i || data_rd_i;
	// Master receive data is timed by our own SCK, slave data by the pin
	assign rx_in      = is_master ? miso_i : mosi_s;
	// Writes reopen once status was read with the done flag up
	assign dr_open    = !stat.transfer_done_flag || done_armed;

	// Phase 0 slave is frozen once selected; phase 1 on its first edge
	assign slave_frozen = slave_sel && (!ctrl.clock_phase
		|| state != sbp_pkg::ST_IDLE);
	assign collision  = data_wr_i && dr_open
		&& (state == sbp_pkg::ST_SHIFT || slave_frozen);
	assign data_wr_ok = data_wr_i && dr_open
		&& !collision;

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			// Reset hands the pins back to the general ports
			ctrl <= '{sbp_pkg::RST_IRQ_ENABLE, sbp_pkg::RST_PORT_ENABLE,
				sbp_pkg::RST_MASTER, 1'b0, 1'b0, sbp_pkg::RST_RATE};
		end else if (fault_evt) begin
			ctrl.port_enable   <= 1'b0;
			ctrl.master_select <= 1'b0;
		end else if (ctrl_wr_i) begin
			ctrl <= ctrl_wdata_i;
			// Fault holds enables low unless this write ends the sequence
			if (stat.mode_fault_flag && !fault_armed) begin
				ctrl.port_enable   <= 1'b0;
				ctrl.master_select <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Master clock generator
	// ----------------------------------------------------------------
	always_comb begin
		unique case (ctrl.rate)
			sbp_pkg::RATE_DIV2:   half_len = sbp_pkg::HALF_DIV2;
			sbp_pkg::RATE_DIV8:   half_len = sbp_pkg::HALF_DIV8;
			sbp_pkg::RATE_DIV16:  half_len = sbp_pkg::HALF_DIV16;
			sbp_pkg::RATE_DIV32:  half_len = sbp_pkg::HALF_DIV32;
			sbp_pkg::RATE_DIV64:  half_len = sbp_pkg::HALF_DIV64;
			sbp_pkg::RATE_DIV128: half_len = sbp_pkg::HALF_DIV128;
			// Unlisted codes fall back to the slowest rate
			default:              half_len = sbp_pkg::HALF_DIV128;
		endcase
	end

	// The counter restarts on every toggle, so the first edge comes a
	// full half period after the write and every half period is exact
	assign master_edge = is_master && state == sbp_pkg::ST_SHIFT
		&& div_cnt == half_len;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_cnt <= 6'h00;
			sck_gen <= 1'b0;
		end else if (state != sbp_pkg::ST_SHIFT || !is_master) begin
			div_cnt <= 6'h00;
			sck_gen <= ctrl.clock_polarity;
		end else if (master_edge) begin
			div_cnt <= 6'h00;
			sck_gen <= !sck_gen;
		end else begin
			div_cnt <= div_cnt + 6'h01;
		end
	end

	// ----------------------------------------------------------------
	// Transfer sequencer and shift register
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state    <= sbp_pkg::ST_IDLE;
			edge_cnt <= 4'h0;
			sck_prev <= 1'b0;
		end else begin
			sck_prev <= sck_s;
			unique case (state)
				sbp_pkg::ST_IDLE: begin
					edge_cnt <= 4'h0;
					if (is_master && ctrl.port_enable && data_wr_ok)
						state <= sbp_pkg::ST_SHIFT;
					else if (slave_edge) begin
						state    <= sbp_pkg::ST_SHIFT;
						edge_cnt <= 4'h1;
					end
				end
				sbp_pkg::ST_SHIFT: begin
					if (byte_end)
						state <= sbp_pkg::ST_DONE;
					else if (any_edge)
						edge_cnt <= edge_cnt + 4'h1;
					// Mode change or deselect mid-byte abandons it
					if (fault_evt || (!is_master && !slave_sel))
						state <= sbp_pkg::ST_IDLE;
				end
				sbp_pkg::ST_DONE: begin
					// One cycle for flag and buffer to land
					state <= sbp_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shift_reg <= sbp_pkg::RST_DATA;
			out_bit   <= 1'b0;
		end else if (state == sbp_pkg::ST_IDLE && data_wr_ok) begin
			shift_reg <= data_wr_i ? data_wdata_i : shift_reg;
			// Phase 0 puts the MSB out before the first edge
			out_bit   <= data_wdata_i[7];
		end else if (cap_edge) begin
			shift_reg <= {shift_reg[6:0],
				rx_in};
		end else if (any_edge) begin
			out_bit   <= shift_reg[7];
		end
	end

	// ----------------------------------------------------------------
	// Status flags and receive buffer
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stat        <= '0;
			done_armed  <= 1'b0;
			fault_armed <= 1'b0;
		end else begin
			// Two-step clearing keeps a stray data access from losing a flag
			if (status_rd_i && stat.transfer_done_flag)
				done_armed <= 1'b1;
			else if (data_acc)
				done_armed <= 1'b0;
			if (status_rd_i && stat.mode_fault_flag)
				fault_armed <= 1'b1;
			else if (ctrl_wr_i)
				fault_armed <= 1'b0;
			// Sets are placed last so a coincident clear loses
			if (done_armed && data_acc) begin
				stat.transfer_done_flag   <= 1'b0;
				stat.write_collision_flag <= 1'b0;
			end
			if (fault_armed && ctrl_wr_i)
				stat.mode_fault_flag <= 1'b0;
			if (byte_end)
				stat.transfer_done_flag <= 1'b1;
			if (collision)
				stat.write_collision_flag <= 1'b1;
			if (fault_evt)
				stat.mode_fault_flag <= 1'b1;
		end
	end

	// First byte after a clear is kept; later ones drop silently
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_buf  <= sbp_pkg::RST_DATA;
			rx_held <= 1'b0;
		end else begin
			if (byte_end && !rx_held) begin
				// Phase 0 ends on a launch edge: the byte is already whole
				rx_buf  <= cap_edge ? {shift_reg[6:0], rx_in}
					: shift_reg;
				rx_held <= 1'b1;
			end else if (!stat.transfer_done_flag)
				rx_held <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			ss_prev <= 1'b1;
		else
			ss_prev <= ss_n_s;
	end

	// Reads see the buffer only, never the live shift register
	assign data_rdata_o = rx_buf;
	assign ctrl_o       = ctrl;
	assign status_o     = stat;
	assign irq_o        = ctrl.serial_irq_enable && !irq_mask_i
		&& (stat.transfer_done_flag || stat.mode_fault_flag);
	assign busy_o       = state != sbp_pkg::ST_IDLE;
	assign sck_o        = sck_gen;
	assign sck_oe_n_o   = !(ctrl.port_enable && is_master);
	assign mosi_o       = out_bit;
	assign mosi_oe_n_o  = !(ctrl.port_enable && is_master);
	assign miso_o       = out_bit;
	// Phase 1 slave keeps MISO off until its first edge
	assign miso_oe_n_o  = !(slave_sel && (!ctrl.clock_phase
		|| state != sbp_pkg::ST_IDLE) && !(ss_prev && ctrl.clock_phase
		&& state == sbp_pkg::ST_IDLE));

endmodule : sbp_port

//--- test/sbp_port_sva.sv
// Purpose: Concurrent checks on the SPI byte port pins and flags
// Assumes: One clock domain, async active-low reset
// Notes:   Pin inputs pass a synchroniser, so pin causes get a window
module sbp_port_sva (
	input wire logic                 ref_clk_i,
	input wire logic                 rst_n_i,
	input wire logic                 irq_mask_i,
	input wire logic                 ctrl_wr_i,
	input wire logic                 status_rd_i,
	input wire logic                 data_wr_i,
	input wire sbp_pkg::sbp_ctrl_t   ctrl_o,
	input wire sbp_pkg::sbp_status_t status_o,
	input wire logic                 irq_o,
	input wire logic                 busy_o,
	input wire logic                 sck_o,
	input wire logic                 sck_oe_n_o,
	input wire logic                 ss_n_i
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	logic sr_seen;
	// Tracks the status access that opens the fault clearing sequence
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) sr_seen <= 1'b0;
		else if (ctrl_wr_i) sr_seen <= 1'b0;
		else if (status_rd_i && status_o.mode_fault_flag) sr_seen <= 1'b1;
	end
	a_master_drives_sck: assert property (
		ctrl_o.port_enable && ctrl_o.master_select && $stable(ctrl_o)
		|-> !sck_oe_n_o) else $error("master not driving clock");
	a_slave_sck_in: assert property (
		!ctrl_o.master_select && $stable(ctrl_o) |-> sck_oe_n_o)
		else $error("clock driven outside master mode");
	a_idle_level: assert property (
		ctrl_o.port_enable && ctrl_o.master_select && !busy_o
		&& !$past(busy_o) && $stable(ctrl_o)
		|-> sck_o == ctrl_o.clock_polarity) else $error("bad idle level");
	a_write_starts: assert property (
		data_wr_i && ctrl_o.port_enable && ctrl_o.master_select && ss_n_i
		&& !busy_o && status_o == '0 |=> busy_o)
		else $error("write did not start transfer");
	a_done_sets: assert property (
		$fell(busy_o) && $past(ctrl_o.master_select)
		&& ctrl_o.master_select && !status_o.mode_fault_flag
		|-> ##[0:2] status_o.transfer_done_flag) else $error("no done flag");
	a_irq_level: assert property (
		irq_o == (ctrl_o.serial_irq_enable && !irq_mask_i
		&& (status_o.transfer_done_flag || status_o.mode_fault_flag)))
		else $error("interrupt level wrong");
	a_busy_write_write_collision_flag: assert property (
		busy_o && data_wr_i && !status_o.transfer_done_flag
		|=> status_o.write_collision_flag)
		else $error("collision not flagged");
	a_fault_sets: assert property (
		$fell(ss_n_i) && ctrl_o.port_enable && ctrl_o.master_select
		|-> ##[1:6] (status_o.mode_fault_flag && !ctrl_o.port_enable
		&& !ctrl_o.master_select)) else $error("mode fault missed");
	a_slave_no_fault: assert property (
		!ctrl_o.master_select [*8] |=> !$rose(status_o.mode_fault_flag))
		else $error("fault set in slave mode");
	a_fault_locks: assert property (
		status_o.mode_fault_flag && ctrl_wr_i && !sr_seen
		|=> !ctrl_o.port_enable && !ctrl_o.master_select)
		else $error("enable set during fault");
endmodule : sbp_port_sva

bind sbp_port sbp_port_sva sbp_port_sva_inst (.ref_clk_i(ref_clk_i),
	.rst_n_i(rst_n_i), .irq_mask_i(irq_mask_i), .ctrl_wr_i(ctrl_wr_i),
	.status_rd_i(status_rd_i), .data_wr_i(data_wr_i), .ctrl_o(ctrl_o),
	.status_o(status_o), .irq_o(irq_o), .busy_o(busy_o), .sck_o(sck_o),
	.sck_oe_n_o(sck_oe_n_o), .ss_n_i(ss_n_i));

//--- test/sbp_slave_model.sv
// Purpose: Behavioural external SPI slave on the far side of the port
// Assumes: Same polarity and phase as the port under test
// Notes:   A released data line toggles so stale bits never pass
module sbp_slave_model (
	input  wire logic       sck_i,
	input  wire logic       mosi_i,
	input  wire logic       sel_n_i,
	input  wire logic       cpol_i,
	input  wire logic       cpha_i,
	input  wire logic [7:0] tx_i,
	output logic            miso_o,
	output logic [7:0]      rx_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] sr;
	initial miso_o = 1'b0;
	always #20 if (sel_n_i) miso_o = ~miso_o;
	always @(negedge sel_n_i) begin
		sr = tx_i;
		rx_o = 8'h00;
		miso_o = sr[7];
	end
	always @(sck_i) if (!sel_n_i) begin
		// Capture on the rising edge when polarity equals phase
		if (sck_i == (cpol_i == cpha_i)) begin
			rx_o = {rx_o[6:0], mosi_i};
			sr = sr << 1;
		end else miso_o = sr[7];
	end
endmodule : sbp_slave_model

//--- test/test_sbp_port.sv
// Purpose: Self-checking bench for the SPI byte port
// Assumes: 25 MHz clock, inputs driven on the falling edge
// Notes:   Slave model answers every master byte with a random byte
module test_sbp_port;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk_i = 0, rst_n_i = 0, irq_mask_i = 0, ctrl_wr_i = 0;
	logic status_rd_i = 0, data_wr_i = 0, data_rd_i = 0, ss_n_i = 1;
	logic sel_n = 1, prev_done = 0, irq_o, busy_o, sck_o, sck_oe_n_o;
	logic mosi_o, mosi_oe_n_o, miso_o, miso_oe_n_o, miso_w;
	logic [7:0] data_wdata_i = 0, data_rdata_o, slv_tx = 0, slv_rx;
	logic [15:0] e;
	logic [15:0] expq[$];
	logic [31:0] rng = 32'h4f;
	sbp_pkg::sbp_ctrl_t ctrl_wdata_i = '0, ctrl_o;
	sbp_pkg::sbp_status_t status_o;
	wire logic sck_w = sck_oe_n_o ? ctrl_o.clock_polarity : sck_o;
	// Undriven data line follows the clock so it never holds a value
	wire logic mosi_w = mosi_oe_n_o ? ref_clk_i : mosi_o;
	int num_errors = 0, n_tests = 0;
	logic [2:0] rc[6] = '{sbp_pkg::RATE_DIV2, sbp_pkg::RATE_DIV8,
		sbp_pkg::RATE_DIV16, sbp_pkg::RATE_DIV32, sbp_pkg::RATE_DIV64,
		sbp_pkg::RATE_DIV128};
	int dv[6] = '{2, 8, 16, 32, 64, 128};
	always #20 ref_clk_i = ~ref_clk_i;
	sbp_port sbp_port_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.irq_mask_i(irq_mask_i), .ctrl_wr_i(ctrl_wr_i),
		.ctrl_wdata_i(ctrl_wdata_i), .status_rd_i(status_rd_i),
		.data_wr_i(data_wr_i), .data_rd_i(data_rd_i),
		.data_wdata_i(data_wdata_i), .data_rdata_o(data_rdata_o),
		.ctrl_o(ctrl_o), .status_o(status_o), .irq_o(irq_o),
		.busy_o(busy_o), .sck_i(sck_w), .sck_o(sck_o),
		.sck_oe_n_o(sck_oe_n_o), .mosi_i(mosi_w), .mosi_o(mosi_o),
		.mosi_oe_n_o(mosi_oe_n_o), .miso_i(miso_w), .miso_o(miso_o),
		.miso_oe_n_o(miso_oe_n_o), .ss_n_i(ss_n_i));
	sbp_slave_model sbp_slave_model_inst (.sck_i(sck_w), .mosi_i(mosi_w),
		.sel_n_i(sel_n), .cpol_i(ctrl_o.clock_polarity),
		.cpha_i(ctrl_o.clock_phase), .tx_i(slv_tx), .miso_o(miso_w),
		.rx_o(slv_rx));
	function automatic logic [7:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng[7:0];
	endfunction : rnd
	task automatic chk_byte(input logic [7:0] got, exp, input string s);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %s %h not %h", $time, s, got, exp);
		end
	endtask : chk_byte
	task automatic chk_bit(input logic got, exp, input string s);
		chk_byte({7'h00, got}, {7'h00, exp}, s);
	endtask : chk_bit
	task automatic pulse(ref logic s);
		@(negedge ref_clk_i) s = 1'b1;
		@(negedge ref_clk_i) s = 1'b0;
		@(negedge ref_clk_i);
	endtask : pulse
	task automatic set_ctrl(input logic pe, ms, cp, ph, input logic [2:0] r);
		ctrl_wdata_i = '{1'b1, pe, ms, cp, ph, r};
		pulse(ctrl_wr_i);
	endtask : set_ctrl
	task automatic start_byte();
		slv_tx = rnd();
		data_wdata_i = rnd();
		sel_n = 1'b0;
		expq.push_back({slv_tx, data_wdata_i});
		pulse(data_wr_i);
	endtask : start_byte
	task automatic wait_done();
		int k;
		for (k = 0; k < 3000 && status_o.transfer_done_flag !== 1'b1; k++)
			@(negedge ref_clk_i);
		if (k == 3000) chk_bit(1'b0, 1'b1, "done timeout");
		sel_n = 1'b1;
	endtask : wait_done
	task automatic xfer(input int i, input logic coll);
		int h;
		logic s0;
		set_ctrl(1'b1, 1'b1, i[0], i[1], rc[i]);
		start_byte();
		s0 = sck_o;
		for (h = 0; h < 300 && sck_o === s0; h++) @(negedge ref_clk_i);
		s0 = sck_o;
		for (h = 0; h < 300 && sck_o === s0; h++) @(negedge ref_clk_i);
		chk_byte(h[7:0], 8'(dv[i] / 2), "half period");
		if (coll) begin
			data_wdata_i = ~data_wdata_i;
			pulse(data_wr_i);
			chk_bit(status_o.write_collision_flag, 1'b1, "write_collision_flag");
		end
		wait_done();
		chk_bit(irq_o, 1'b1, "done irq");
		pulse(status_rd_i);
		pulse(data_rd_i);
		chk_byte({5'h00, status_o}, 8'h00, "flags cleared");
	endtask : xfer
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : complete_run
	// --------------------------------------------------------------
	// Result watcher: one queued note per completed byte
	// --------------------------------------------------------------
	always @(negedge ref_clk_i) begin
		if (status_o.transfer_done_flag === 1'b1 && !prev_done) begin
			e = expq.pop_front();
			chk_byte(data_rdata_o, e[15:8], "rx buffer");
			chk_byte(slv_rx, e[7:0], "slave rx");
		end
		prev_done <= status_o.transfer_done_flag;
	end
	initial begin
		#1000000;
		num_errors++;
		complete_run();
	end
	initial begin
		repeat (12) @(negedge ref_clk_i);
		rst_n_i = 1'b1;
		@(negedge ref_clk_i);
		chk_byte(ctrl_o, 8'h00, "ctrl reset");
		chk_bit(sck_oe_n_o & mosi_oe_n_o & miso_oe_n_o, 1'b1, "pins");
		for (int i = 0; i < 6; i++) xfer(i, 1'b0);
		xfer(0, 1'b1);
		$display("test rates and modes done");
		irq_mask_i = 1'b1;
		start_byte();
		wait_done();
		chk_bit(irq_o, 1'b0, "masked irq");
		pulse(data_wr_i);
		chk_bit(busy_o, 1'b0, "write while done");
		chk_bit(status_o.write_collision_flag, 1'b0, "no write_collision_flag");
		pulse(status_rd_i);
		pulse(data_rd_i);
		chk_bit(status_o.transfer_done_flag, 1'b0, "done clear");
		$display("test done flag done");
		irq_mask_i = 1'b0;
		set_ctrl(1'b1, 1'b1, 1'b0, 1'b0, sbp_pkg::RATE_DIV8);
		ss_n_i = 1'b0;
		repeat (8) @(negedge ref_clk_i);
		chk_bit(status_o.mode_fault_flag, 1'b1, "mode_fault_flag");
		chk_bit(ctrl_o.port_enable | ctrl_o.master_select, 1'b0, "off");
		chk_bit(irq_o, 1'b1, "fault irq");
		ss_n_i = 1'b1;
		set_ctrl(1'b1, 1'b1, 1'b0, 1'b0, sbp_pkg::RATE_DIV8);
		chk_bit(ctrl_o.master_select, 1'b0, "locked");
		pulse(status_rd_i);
		set_ctrl(1'b1, 1'b1, 1'b0, 1'b0, sbp_pkg::RATE_DIV8);
		chk_bit(status_o.mode_fault_flag, 1'b0, "mode_fault_flag clear");
		chk_bit(ctrl_o.master_select, 1'b1, "restored");
		$display("test mode fault done");
		set_ctrl(1'b1, 1'b0, 1'b0, 1'b0, sbp_pkg::RATE_DIV2);
		chk_bit(sck_oe_n_o, 1'b1, "slave clock in");
		data_wdata_i = rnd();
		pulse(data_wr_i);
		ss_n_i = 1'b0;
		repeat (6) @(negedge ref_clk_i);
		chk_bit(miso_oe_n_o, 1'b0, "miso driven");
		chk_bit(miso_o, data_wdata_i[7], "miso msb");
		pulse(data_wr_i);
		chk_bit(status_o.write_collision_flag, 1'b1, "locked dr");
		set_ctrl(1'b1, 1'b0, 1'b0, 1'b1, sbp_pkg::RATE_DIV2);
		chk_bit(miso_oe_n_o, 1'b1, "miso held off");
		ss_n_i = 1'b1;
		$display("test slave lock done");
		complete_run();
	end
endmodule : test_sbp_port
